// ===== lvr_params.svh
// Offsets, codes, field positions and timing counts of the reset block
`ifndef LVR_PARAMS_SVH
`define LVR_PARAMS_SVH

// Register byte offsets on the bus
`define OFS_THRESHOLD_SELECT 8'h00
`define OFS_RESET_CAUSE      8'h04
`define OFS_FLASH_CONTROL    8'h08
`define OFS_CORE_STATUS      8'h0c

// Trip level codes
`define CODE_1V7      8'h66
`define CODE_1V9      8'h55
`define CODE_2V55     8'h33
`define CODE_3V15     8'h99
`define CODE_3V8      8'haa
`define CODE_LVR_OFF  8'hf0
`define SELECT_POR    8'h66

// Flash control key and its reset value
`define FLASH_RESET_KEY 8'h55
`define FLASH_CTRL_POR  8'h00

// Reset cause flag positions
`define BIT_DIP_FLAG     2
`define BIT_CORRUPT_FLAG 1

// Core status bit positions
`define BIT_EXPIRY    0
`define BIT_PDOWN     1
`define BIT_ARMED     2
`define BIT_IN_RESET  3

// Timing: clock rate, times in ns, derived cycle counts (least times round up)
`define CLOCK_MHZ          250
`define DIP_QUALIFY_NS     120000
`define SW_RESET_DELAY_NS  45000
`define DIP_QUALIFY_CYCLES ((`DIP_QUALIFY_NS * `CLOCK_MHZ + 999) / 1000)
`define SW_RESET_CYCLES    ((`SW_RESET_DELAY_NS * `CLOCK_MHZ + 999) / 1000)
`define RESET_HOLD_CYCLES  16'h0010
`define CNT_W              16

`endif

// ===== lvr_pkg.sv
// Types shared by the reset and flags block
package lvr_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DELAY = 2'b01,
    ST_HOLD  = 2'b10
  } seq_state_type;

  // Decoded trip level
  typedef enum logic [2:0] {
    LVL_1V7     = 3'b000,
    LVL_1V9     = 3'b001,
    LVL_2V55    = 3'b010,
    LVL_3V15    = 3'b011,
    LVL_3V8     = 3'b100,
    LVL_OFF     = 3'b101,
    LVL_INVALID = 3'b110
  } trip_level_type;

  // What started the current full reset
  typedef enum logic [2:0] {
    CAUSE_POR   = 3'b000,
    CAUSE_DIP   = 3'b001,
    CAUSE_CODE  = 3'b010,
    CAUSE_FLASH = 3'b011,
    CAUSE_WDOG  = 3'b100
  } reset_cause_type;

  // Initialisation commands to the core units
  typedef struct packed {
    logic regs_init;
    logic wdt_clear;
    logic int_disable;
    logic timers_off;
    logic ports_input;
    logic pc_zero;
    logic sp_top;
  } core_init_type;

endpackage

// ===== low_voltage_reset_and_flags.sv
// Low-voltage reset, select check, cause flags and reset sequencing
//
// What this block does
// (R1) Select code picks one of five trip levels
// (R2) Code f0 disables monitor, no reset
// (R3) Other codes reset after delay, restore select
// (R4) Dip must outlast qualify time to reset
// (R5) Dip reset keeps the select register value
// (R6) Dip flag bit 2, cleared by zero write
// (R7) Corruption flag bit 1, cleared by zero
// (R8) Flag bits 7 to 4 read zero
// (R9) Key 55 to flash control resets device
// (R10) Normal watchdog expiry: full reset, expiry flag
// (R11) Sleep expiry: clear PC/SP, set both flags
// (R12) Power-on clears flags; dip leaves them
// (R13) Power-on clears watchdog, then it counts
// (R14) Power-on disables all interrupts
// (R15) Power-on stops timers, ports become inputs
// (R16) Power-on zeroes PC, stack at top
// (R17) Each reset kind loads its own values
// (R18) Monitor disabled in sleep or idle
// (R19) Supply low only between floor and trip
// (R20) Delay and qualify times are parameters
// (R21) Cause flags cleared only by power-on or a zero write
`timescale 1ns/1ps
`include "lvr_params.svh"

module low_voltage_reset_and_flags
#(
  parameter logic [`CNT_W-1:0] DIP_QUALIFY_CYCLES = `CNT_W'(`DIP_QUALIFY_CYCLES),
  parameter logic [`CNT_W-1:0] SW_RESET_CYCLES    = `CNT_W'(`SW_RESET_CYCLES)
)
(
  // Clock and power-on reset
  input  wire logic                   CLOCK_IN,
  input  wire logic                   RST_N_IN,
  // Wishbone slave
  input  wire logic                   WB_CYC_IN,
  input  wire logic                   WB_STB_IN,
  input  wire logic                   WB_WE_IN,
  input  wire logic [7:0]             WB_ADR_IN,
  input  wire logic [3:0]             WB_SEL_IN,
  input  wire logic [31:0]            WB_DAT_IN,
  output logic      [31:0]            WB_DAT_OUT,
  output logic                        WB_ACK_OUT,
  // Supply comparators, asynchronous
  input  wire logic                   BELOW_TRIP_IN,
  input  wire logic                   ABOVE_FLOOR_IN,
  // Core events, same clock
  input  wire logic                   SLEEP_MODE_IN,
  input  wire logic                   WDT_TIMEOUT_IN,
  input  wire logic                   STATUS_CLEAR_IN,
  // Reset outputs
  output logic                        SYS_RESET_OUT,
  output lvr_pkg::core_init_type      CORE_INIT_OUT,
  output lvr_pkg::trip_level_type     TRIP_LEVEL_OUT,
  output logic                        LVR_ARMED_OUT,
  output logic                        WATCHDOG_EXPIRY_OUT,
  output logic                        POWER_DOWN_OUT
);
  import lvr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Map a select code to its trip level
  function automatic trip_level_type decode_level(input logic [7:0] code);
    case (code)
      `CODE_1V7:     decode_level = LVL_1V7;
      `CODE_1V9:     decode_level = LVL_1V9;
      `CODE_2V55:    decode_level = LVL_2V55;
      `CODE_3V15:    decode_level = LVL_3V15;
      `CODE_3V8:     decode_level = LVL_3V8;
      `CODE_LVR_OFF: decode_level = LVL_OFF;
      default:       decode_level = LVL_INVALID;
    endcase
  endfunction

  // Word address match on a byte offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers

  logic [2:0] below_q;   // Three-stage chain, below trip
  logic [2:0] below_d;
  logic [2:0] floor_q;   // Three-stage chain, above floor
  logic [2:0] floor_d;
  logic       below_f_q; // Agreed level, below trip
  logic       below_f_d;
  logic       floor_f_q; // Agreed level, above floor
  logic       floor_f_d;

  // Shift pins in; accept a level once stages two and three agree
  always_comb
  begin
    below_d   = {below_q[1:0], BELOW_TRIP_IN};
    floor_d   = {floor_q[1:0], ABOVE_FLOOR_IN};
    below_f_d = below_f_q;
    floor_f_d = floor_f_q;
    if (below_q[1] == below_q[2])
    begin
      below_f_d = below_q[2];
    end
    if (floor_q[1] == floor_q[2])
    begin
      floor_f_d = floor_q[2];
    end
  end

  // Register the chains
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      below_q   <= 3'h0;
      floor_q   <= 3'h0;
      below_f_q <= 1'b0;
      floor_f_q <= 1'b0;
    end
    else
    begin
      below_q   <= below_d;
      floor_q   <= floor_d;
      below_f_q <= below_f_d;
      floor_f_q <= floor_f_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic        ack_q;  // Acknowledge
  logic        ack_d;
  logic [31:0] dat_q;  // Read data
  logic [31:0] dat_d;
  logic        req;    // New request this cycle
  logic        wr;     // Write of the low byte
  logic [7:0]  wdat;   // Written byte

  // Registers of the main group, read below
  logic [7:0]      sel_q;
  logic [1:0]      flags_q;
  logic [7:0]      fc_q;
  logic            to_q;
  logic            pdn_q;
  logic            armed_q;
  seq_state_type   state_q;

  // One-wait-state answer; unmapped reads return zero
  always_comb
  begin
    req   = WB_CYC_IN && WB_STB_IN && !ack_q;
    // Write lands only at the edge where the master samples ack
    wr    = WB_CYC_IN && WB_STB_IN && ack_q && WB_WE_IN && WB_SEL_IN[0];
    wdat  = WB_DAT_IN[7:0];
    ack_d = req;
    dat_d = 32'h0;
    if (req && !WB_WE_IN)
    begin
      if (hit(WB_ADR_IN, `OFS_THRESHOLD_SELECT))
      begin
        dat_d[7:0] = sel_q;
      end
      else if (hit(WB_ADR_IN, `OFS_RESET_CAUSE))
      begin
        // Upper bits stay zero
        dat_d[`BIT_DIP_FLAG]     = flags_q[1]; // R6 R8
        dat_d[`BIT_CORRUPT_FLAG] = flags_q[0]; // R7
      end
      else if (hit(WB_ADR_IN, `OFS_FLASH_CONTROL))
      begin
        dat_d[7:0] = fc_q;
      end
      else if (hit(WB_ADR_IN, `OFS_CORE_STATUS))
      begin
        dat_d[`BIT_EXPIRY]   = to_q;
        dat_d[`BIT_PDOWN]    = pdn_q;
        dat_d[`BIT_ARMED]    = armed_q;
        dat_d[`BIT_IN_RESET] = (state_q == ST_HOLD);
      end
      else
      begin
        dat_d = 32'h0;
      end
    end
  end

  // Register the answer
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer and registers

  logic [7:0]         sel_d;     // Threshold select
  logic [1:0]         flags_d;   // {dip, corruption}
  logic [7:0]         fc_d;      // Flash control second
  logic               to_d;      // Watchdog expiry flag
  logic               pdn_d;     // Power-down flag
  logic               armed_d;   // Monitor active
  seq_state_type      state_d;
  reset_cause_type    cause_q;   // Cause of current hold
  reset_cause_type    cause_d;
  logic [`CNT_W-1:0]  cnt_q;     // Delay and hold counter
  logic [`CNT_W-1:0]  cnt_d;
  logic [`CNT_W-1:0]  dip_q;     // Low-supply duration
  logic [`CNT_W-1:0]  dip_d;
  logic               sysrst_q;  // Full reset output
  logic               sysrst_d;
  core_init_type      init_q;    // Core init commands
  core_init_type      init_d;
  trip_level_type     lvl_q;     // Level output
  trip_level_type     lvl;       // Decoded current select
  logic               dip_now;   // Qualified-low condition
  logic               dip_hit;   // Dip lasted long enough
  logic               fc_key;    // Flash reset key write
  logic               active;    // Not holding reset
  logic [1:0]         set_f;     // Flag set events
  logic [1:0]         clr_f;     // Flag clear writes

  // Next state of the whole sequencer
  always_comb
  begin
    lvl      = decode_level(sel_q); // R1
    active   = (state_q != ST_HOLD);
    // Monitor off in sleep, when disabled, or on a bad code
    armed_d  = !SLEEP_MODE_IN && (lvl != LVL_OFF) && (lvl != LVL_INVALID); // R2 R18
    // Low only between the floor and the trip level
    dip_now  = armed_q && below_f_q && floor_f_q; // R19
    dip_hit  = dip_now && (dip_q >= DIP_QUALIFY_CYCLES); // R4 R20
    fc_key   = active && wr && hit(WB_ADR_IN, `OFS_FLASH_CONTROL)
               && (wdat == `FLASH_RESET_KEY); // R9
    sel_d    = sel_q;
    fc_d     = fc_q;
    to_d     = to_q;
    pdn_d    = pdn_q;
    state_d  = state_q;
    cause_d  = cause_q;
    cnt_d    = cnt_q;
    sysrst_d = 1'b0;
    init_d   = '0;
    set_f    = 2'b00;
    clr_f    = 2'b00;
    // Qualify counter runs only while low and running
    if (dip_now && (state_q == ST_RUN))
    begin
      if (dip_q != {`CNT_W{1'b1}})
      begin
        dip_d = dip_q + `CNT_W'(1);
      end
      else
      begin
        dip_d = dip_q;
      end
    end
    else
    begin
      dip_d = '0; // R4
    end
    // Software access while not in reset
    if (active && wr)
    begin
      if (hit(WB_ADR_IN, `OFS_THRESHOLD_SELECT))
      begin
        sel_d = wdat;
      end
      else if (hit(WB_ADR_IN, `OFS_RESET_CAUSE))
      begin
        // Writing zero clears; writing one does nothing
        clr_f[1] = !wdat[`BIT_DIP_FLAG]; // R6
        clr_f[0] = !wdat[`BIT_CORRUPT_FLAG]; // R7
      end
      else if (hit(WB_ADR_IN, `OFS_FLASH_CONTROL))
      begin
        fc_d = wdat;
      end
      else
      begin
        fc_d = fc_q;
      end
    end
    // Core may clear the status flags
    if (STATUS_CLEAR_IN)
    begin
      to_d  = 1'b0;
      pdn_d = 1'b0;
    end
    case (state_q)
      ST_RUN:
      begin
        cnt_d = '0;
        if (fc_key)
        begin
          state_d = ST_HOLD; // R9
          cause_d = CAUSE_FLASH;
        end
        else if (WDT_TIMEOUT_IN && !SLEEP_MODE_IN)
        begin
          state_d = ST_HOLD; // R10
          cause_d = CAUSE_WDOG;
          to_d    = 1'b1;
        end
        else if (WDT_TIMEOUT_IN)
        begin
          // Only PC and SP, registers untouched
          init_d.pc_zero = 1'b1; // R11 R17
          init_d.sp_top  = 1'b1;
          to_d           = 1'b1;
          pdn_d          = 1'b1;
        end
        else if (dip_hit)
        begin
          state_d  = ST_HOLD; // R4
          cause_d  = CAUSE_DIP;
          set_f[1] = 1'b1; // R6
        end
        else if (lvl == LVL_INVALID)
        begin
          state_d  = ST_DELAY; // R3
          cause_d  = CAUSE_CODE;
          set_f[0] = 1'b1; // R7
        end
        else
        begin
          state_d = ST_RUN;
        end
      end
      ST_DELAY:
      begin
        // Committed: wait out the software reset delay
        if (cnt_q >= SW_RESET_CYCLES - `CNT_W'(1))
        begin
          state_d = ST_HOLD; // R3 R20
          cnt_d   = '0;
        end
        else
        begin
          cnt_d = cnt_q + `CNT_W'(1);
        end
      end
      ST_HOLD:
      begin
        sysrst_d = 1'b1;
        // Full reset: registers and core units to initial values
        init_d   = '1; // R13 R14 R15 R16 R17
        if (cnt_q >= `RESET_HOLD_CYCLES - `CNT_W'(1))
        begin
          // Release; watchdog starts counting from here
          state_d  = ST_RUN; // R13
          cnt_d    = '0;
          sysrst_d = 1'b0;
          init_d   = '0;
        end
        else
        begin
          cnt_d = cnt_q + `CNT_W'(1);
        end
      end
      default:
      begin
        state_d = ST_HOLD;
        cnt_d   = '0;
      end
    endcase
    // Entry into a hold loads per-kind register values
    if ((state_q != ST_HOLD) && (state_d == ST_HOLD))
    begin
      cnt_d = '0;
      fc_d  = `FLASH_CTRL_POR;
      // Dip reset keeps the select; others restore it
      if (cause_d != CAUSE_DIP)
      begin
        sel_d = `SELECT_POR; // R3 R5 R17
      end
      else
      begin
        sel_d = sel_q; // R5
      end
    end
    // Set wins over a same-cycle clear
    flags_d = (flags_q & ~clr_f) | set_f;
  end

  // Register the sequencer; flags only by power-on reset
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      sel_q    <= `SELECT_POR;
      flags_q  <= 2'b00; // R21
      fc_q     <= `FLASH_CTRL_POR;
      to_q     <= 1'b0; // R12
      pdn_q    <= 1'b0; // R12
      armed_q  <= 1'b0;
      state_q  <= ST_HOLD; // R13
      cause_q  <= CAUSE_POR;
      cnt_q    <= '0;
      dip_q    <= '0;
      sysrst_q <= 1'b1;
      init_q   <= '1; // R14 R15 R16
      lvl_q    <= LVL_1V7;
    end
    else
    begin
      sel_q    <= sel_d;
      flags_q  <= flags_d;
      fc_q     <= fc_d;
      to_q     <= to_d;
      pdn_q    <= pdn_d;
      armed_q  <= armed_d;
      state_q  <= state_d;
      cause_q  <= cause_d;
      cnt_q    <= cnt_d;
      dip_q    <= dip_d;
      sysrst_q <= sysrst_d;
      init_q   <= init_d;
      lvl_q    <= lvl;
    end
  end

  // Outputs straight from flip-flops
  assign WB_ACK_OUT          = ack_q;
  assign WB_DAT_OUT          = dat_q;
  assign SYS_RESET_OUT       = sysrst_q;
  assign CORE_INIT_OUT       = init_q;
  assign TRIP_LEVEL_OUT      = lvl_q;
  assign LVR_ARMED_OUT       = armed_q;
  assign WATCHDOG_EXPIRY_OUT = to_q;
  assign POWER_DOWN_OUT      = pdn_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_off_no_reset: assert property ( // R2
    (state_q == ST_RUN && sel_q == `CODE_LVR_OFF && !fc_key && !WDT_TIMEOUT_IN)
    |=> (state_q == ST_RUN))
    else $error("disable code started a reset");

  a_bad_code_reset: assert property ( // R3
    (state_q == ST_DELAY && cnt_q == SW_RESET_CYCLES - `CNT_W'(1))
    |=> (state_q == ST_HOLD && sel_q == `SELECT_POR) ##1 SYS_RESET_OUT)
    else $error("bad code did not reset with POR select");

  a_dip_qualified: assert property ( // R4
    (state_q == ST_RUN ##1 state_q == ST_HOLD && cause_q == CAUSE_DIP)
    |-> ($past(dip_q) >= DIP_QUALIFY_CYCLES))
    else $error("dip reset before qualify time");

  a_dip_keeps_sel: assert property ( // R5
    (state_q == ST_RUN ##1 state_q == ST_HOLD && cause_q == CAUSE_DIP)
    |-> (sel_q == $past(sel_q) && flags_q[1]))
    else $error("dip reset changed select or missed flag");

  a_corrupt_flag: assert property ( // R7
    (state_q == ST_RUN && lvl == LVL_INVALID && !fc_key && !WDT_TIMEOUT_IN && !dip_hit)
    |=> (flags_q[0] && state_q == ST_DELAY))
    else $error("corruption flag not set");

  a_flags_upper_zero: assert property ( // R8
    (ack_d && !WB_WE_IN && hit(WB_ADR_IN, `OFS_RESET_CAUSE))
    |=> (WB_DAT_OUT[31:3] == 29'h0 && WB_DAT_OUT[0] == 1'b0))
    else $error("unimplemented flag bits read nonzero");

  a_flash_key: assert property ( // R9
    fc_key |=> (state_q == ST_HOLD && cause_q == CAUSE_FLASH) ##1 SYS_RESET_OUT)
    else $error("flash key did not reset");

  a_wdog_normal: assert property ( // R10
    (state_q == ST_RUN && WDT_TIMEOUT_IN && !SLEEP_MODE_IN && !fc_key)
    |=> (state_q == ST_HOLD && WATCHDOG_EXPIRY_OUT))
    else $error("normal expiry missed reset or flag");

  a_wdog_sleep: assert property ( // R11
    (state_q == ST_RUN && WDT_TIMEOUT_IN && SLEEP_MODE_IN && !fc_key)
    |=> (!SYS_RESET_OUT && CORE_INIT_OUT.pc_zero && !CORE_INIT_OUT.regs_init
         && WATCHDOG_EXPIRY_OUT && POWER_DOWN_OUT))
    else $error("sleep expiry handled wrongly");

  a_dip_status_kept: assert property ( // R12
    (state_q == ST_RUN ##1 state_q == ST_HOLD && cause_q == CAUSE_DIP && !$past(STATUS_CLEAR_IN))
    |-> (to_q == $past(to_q) && pdn_q == $past(pdn_q)))
    else $error("dip reset altered status flags");

  a_sleep_disarm: assert property ( // R18
    SLEEP_MODE_IN |=> !LVR_ARMED_OUT)
    else $error("monitor armed in sleep");

  c_dip_reset:   cover property (state_q == ST_HOLD && cause_q == CAUSE_DIP);
  c_code_reset:  cover property (state_q == ST_DELAY ##1 state_q == ST_HOLD);
  c_flash_reset: cover property (fc_key);
  c_sleep_wdog:  cover property (CORE_INIT_OUT.pc_zero && !SYS_RESET_OUT);

endmodule

// ===== tb_low_voltage_reset_and_flags.sv
// Self-checking testbench for the low-voltage reset and flags block
`timescale 1ns/1ps
`include "lvr_params.svh"

module tb_low_voltage_reset_and_flags;
  import lvr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic            clk;        // 250 MHz clock
  logic            rst_n;      // Power-on reset, active low
  logic            cyc;        // Wishbone cycle
  logic            stb;        // Wishbone strobe
  logic            we;         // Write enable
  logic [7:0]      adr;        // Byte address
  logic [3:0]      sel;        // Byte enables
  logic [31:0]     dat_w;      // Write data
  logic [31:0]     dat_r;      // Read data
  logic            ack;        // Acknowledge
  logic            below;      // Supply below trip level
  logic            above;      // Supply above floor
  logic            sleep;      // Sleep or idle mode
  logic            wdt;        // Watchdog expiry pulse
  logic            sclr;       // Status clear pulse
  logic            sys_rst;    // Full device reset
  core_init_type   core_init;  // Core init commands
  trip_level_type  trip;       // Decoded level
  logic            armed;      // Monitor active
  logic            expiry;     // Expiry flag
  logic            pdown;      // Power-down flag
  int              n_errors;   // Mismatch count
  int              compares;   // Comparison count

  ////////////////////////////////////////////////////////////////////////////
  // Design with short counts
  low_voltage_reset_and_flags
  #(
    .DIP_QUALIFY_CYCLES (16'h0008),
    .SW_RESET_CYCLES    (16'h000a)
  )
  dut
  (
    .CLOCK_IN            (clk),
    .RST_N_IN            (rst_n),
    .WB_CYC_IN           (cyc),
    .WB_STB_IN           (stb),
    .WB_WE_IN            (we),
    .WB_ADR_IN           (adr),
    .WB_SEL_IN           (sel),
    .WB_DAT_IN           (dat_w),
    .WB_DAT_OUT          (dat_r),
    .WB_ACK_OUT          (ack),
    .BELOW_TRIP_IN       (below),
    .ABOVE_FLOOR_IN      (above),
    .SLEEP_MODE_IN       (sleep),
    .WDT_TIMEOUT_IN      (wdt),
    .STATUS_CLEAR_IN     (sclr),
    .SYS_RESET_OUT       (sys_rst),
    .CORE_INIT_OUT       (core_init),
    .TRIP_LEVEL_OUT      (trip),
    .LVR_ARMED_OUT       (armed),
    .WATCHDOG_EXPIRY_OUT (expiry),
    .POWER_DOWN_OUT      (pdown)
  );

  // Free-running clock
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Report helpers
  task automatic give_verdict();
    begin
      $display("Comparisons %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus and wait helpers
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      dat_w <= {24'h000000, d};
      do
      begin
        @(posedge clk);
        n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1)
      begin
        n_errors++;
        give_verdict();
      end
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    begin
      wb(a, 1'b1, d, q);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    begin
      wb(a, 1'b0, 8'h00, q);
      chk(q, exp);
    end
  endtask

  // Bounded wait for a reset level
  task automatic wait_lvl(input logic v, input int lim);
    int n;
    begin
      n = 0;
      while (sys_rst !== v && n < lim)
      begin
        @(posedge clk);
        n++;
      end
      if (sys_rst !== v)
      begin
        n_errors++;
        give_verdict();
      end
    end
  endtask

  // Reset must stay low for n cycles
  task automatic quiet(input int n);
    int hits;
    begin
      hits = 0;
      repeat (n)
      begin
        @(posedge clk);
        if (sys_rst !== 1'b0)
          hits++;
      end
      chk(hits, 0);
    end
  endtask

  // Full reset: all init commands, then release
  task automatic full_reset(input int lim);
    begin
      wait_lvl(1'b1, lim);
      chk({25'h0, core_init}, 32'h7f);
      wait_lvl(1'b0, 40);
    end
  endtask

  // One-cycle pulse: 1 on the watchdog input, 0 on status clear
  task automatic pulse(input logic w);
    begin
      if (w)
        wdt <= 1'b1;
      else
        sclr <= 1'b1;
      @(posedge clk);
      if (w)
        wdt <= 1'b0;
      else
        sclr <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Power-on values
  task automatic t_por();
    begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({25'h0, core_init}, 32'h7f);
      rst_n <= 1'b1;
      wait_lvl(1'b0, 40);
      rd(`OFS_THRESHOLD_SELECT, 32'h66);
      rd(`OFS_RESET_CAUSE, 32'h00);
      rd(`OFS_CORE_STATUS, 32'h04);
      rd(`OFS_FLASH_CONTROL, 32'h00);
      rd(8'h10, 32'h00);
      chk({30'h0, expiry, pdown}, 32'h0);
    end
  endtask

  // Every level code and the off code
  task automatic t_codes();
    logic [7:0]     c [6];
    trip_level_type l [6];
    begin
      c = '{`CODE_1V7, `CODE_1V9, `CODE_2V55, `CODE_3V15, `CODE_3V8, `CODE_LVR_OFF};
      l = '{LVL_1V7, LVL_1V9, LVL_2V55, LVL_3V15, LVL_3V8, LVL_OFF};
      foreach (c[i])
      begin
        wr(`OFS_THRESHOLD_SELECT, c[i]);
        rd(`OFS_THRESHOLD_SELECT, {24'h0, c[i]});
        chk({29'h0, trip}, {29'h0, l[i]});
      end
      chk({31'h0, armed}, 32'h0);
      quiet(30);
    end
  endtask

  // Watchdog in normal running
  task automatic t_wdog();
    begin
      wr(`OFS_THRESHOLD_SELECT, `CODE_2V55);
      pulse(1'b1);
      full_reset(10);
      chk({30'h0, expiry, pdown}, 32'h2);
      rd(`OFS_THRESHOLD_SELECT, 32'h66);
      rd(`OFS_CORE_STATUS, 32'h05);
    end
  endtask

  // Short dip, dip under floor, dip in sleep, real dip
  task automatic t_dip();
    begin
      wr(`OFS_THRESHOLD_SELECT, `CODE_2V55);
      below <= 1'b1;
      repeat (4) @(posedge clk);
      below <= 1'b0;
      quiet(30);
      above <= 1'b0;
      below <= 1'b1;
      quiet(40);
      below <= 1'b0;
      @(posedge clk);
      above <= 1'b1;
      sleep <= 1'b1;
      @(posedge clk);
      below <= 1'b1;
      quiet(40);
      rd(`OFS_CORE_STATUS, 32'h01);
      below <= 1'b0;
      sleep <= 1'b0;
      repeat (4) @(posedge clk);
      below <= 1'b1;
      wait_lvl(1'b1, 40);
      below <= 1'b0;
      wait_lvl(1'b0, 40);
      rd(`OFS_THRESHOLD_SELECT, {24'h0, `CODE_2V55});
      rd(`OFS_RESET_CAUSE, 32'h04);
      rd(`OFS_CORE_STATUS, 32'h05);
      wr(`OFS_RESET_CAUSE, 8'h00);
      rd(`OFS_RESET_CAUSE, 32'h00);
    end
  endtask

  // Undefined code, then the flash key
  task automatic t_badcode();
    begin
      wr(`OFS_THRESHOLD_SELECT, 8'h12);
      @(posedge clk);
      chk({29'h0, trip}, {29'h0, LVL_INVALID});
      full_reset(40);
      rd(`OFS_THRESHOLD_SELECT, 32'h66);
      rd(`OFS_RESET_CAUSE, 32'h02);
      wr(`OFS_RESET_CAUSE, 8'hf6);
      rd(`OFS_RESET_CAUSE, 32'h02);
      wr(`OFS_FLASH_CONTROL, `FLASH_RESET_KEY);
      full_reset(10);
      rd(`OFS_FLASH_CONTROL, 32'h00);
      rd(`OFS_RESET_CAUSE, 32'h02);
      wr(`OFS_RESET_CAUSE, 8'h00);
      rd(`OFS_RESET_CAUSE, 32'h00);
    end
  endtask

  // Watchdog in sleep, status clear, then power-on again
  task automatic t_sleep_wdog();
    begin
      wr(`OFS_THRESHOLD_SELECT, `CODE_3V8);
      sleep <= 1'b1;
      pulse(1'b0);
      pulse(1'b1);
      @(posedge clk);
      chk({25'h0, core_init}, 32'h03);
      chk({30'h0, expiry, pdown}, 32'h3);
      quiet(20);
      rd(`OFS_CORE_STATUS, 32'h03);
      rd(`OFS_THRESHOLD_SELECT, {24'h0, `CODE_3V8});
      pulse(1'b0);
      @(posedge clk);
      rd(`OFS_CORE_STATUS, 32'h00);
      pulse(1'b1);
      sleep <= 1'b0;
      t_por();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    dat_w = 32'h0;
    below = 1'b0;
    above = 1'b1;
    sleep = 1'b0;
    wdt = 1'b0;
    sclr = 1'b0;
    n_errors = 0;
    compares = 0;
    t_por();
    t_codes();
    t_wdog();
    t_dip();
    t_badcode();
    t_sleep_wdog();
    give_verdict();
  end
endmodule
